// >>> cocs_regs.svh
// Offsets, field positions, codes and reset values of the CAN object handler.
// Included by the package and by the design modules; definitions only.
`ifndef COCS_REGS_SVH
`define COCS_REGS_SVH

// Object indexes seen from the network
`define COCS_OBJ_DIAG_CLEAR     16'h221f
`define COCS_OBJ_RUN_STOP       16'h2220
`define COCS_OBJ_STATUS         16'h2221

// Receive process data object: byte n (1-based) sits at bits 8*(n-1)+7:8*(n-1)
`define COCS_RX_W               32
`define COCS_RX_POS_LSB         0
`define COCS_RX_DIAG_LSB        16
`define COCS_RX_CMD_LSB         24

// Position demand codes
`define COCS_POS_FULL           16'h9c40
`define COCS_POS_MAX            16'hfaff
`define COCS_POS_RST            16'h0000

// Field positions inside the command bytes
`define COCS_DIAG_ACT_LSB       0
`define COCS_DIAG_LOG_LSB       2
`define COCS_RUN_LSB            0
`define COCS_CMD_BIT_GO         0
`define COCS_CMD_BIT_DIS        1

// Two-bit command codes
`define COCS_CODE_IDLE          2'h0
`define COCS_CODE_GO            2'h1

// Status byte layout
`define COCS_ST_OP_LSB          0
`define COCS_ST_DO_BIT          4
`define COCS_ST_DMD_LSB         5
`define COCS_ST_RST             8'h00

`endif

// >>> cocs_pkg.sv
// Types shared by the CAN object handler modules.
// Expects cocs_regs.svh on the include path.
`include "cocs_regs.svh"

package cocs_pkg;

    typedef enum logic [3:0]
    {
        COCS_OP_NORMAL   = 4'h0,
        COCS_OP_ALARM    = 4'h1,
        COCS_OP_ALARM_HI = 4'h2,
        COCS_OP_DERATE   = 4'h3,
        COCS_OP_CTRL_SD  = 4'h4,
        COCS_OP_LIMP_SD  = 4'h5,
        COCS_OP_ERROR    = 4'he,
        COCS_OP_NA       = 4'hf
    } cocs_op_status_t;

    typedef enum logic [2:0]
    {
        COCS_DMD_PRIMARY     = 3'h0,
        COCS_DMD_PRI_BKP_FLT = 3'h1,
        COCS_DMD_BACKUP      = 3'h2,
        COCS_DMD_ALL_FAILED  = 3'h3,
        COCS_DMD_PRI_DELAYED = 3'h4,
        COCS_DMD_RESERVED    = 3'h5,
        COCS_DMD_ERROR       = 3'h6,
        COCS_DMD_NA          = 3'h7
    } cocs_dmd_state_t;

    // Index of each edge-triggered command channel
    typedef enum int
    {
        COCS_CH_CLR_ACT = 0,
        COCS_CH_CLR_LOG = 1,
        COCS_CH_STOP    = 2
    } cocs_chan_t;

endpackage

// >>> cocs_cmd_if.sv
// Carrier between the handler and one edge-triggered command decoder.
// Same clock on both sides; strobe is a one-cycle pulse.
`timescale 1ns/1ns

interface cocs_cmd_if;
    logic       strobe;
    logic       hold;
    logic [1:0] code;
    logic       fire;

    modport src
    (
        output strobe,
        output hold,
        output code,
        input  fire
    );

    modport dec
    (
        input  strobe,
        input  hold,
        input  code,
        output fire
    );
endinterface

// >>> cocs_edge_cmd.sv
// Edge-triggered two-bit command decoder: go bit plus disable bit.
// Assumes one strobe per received message, in the ref_clk domain.
`timescale 1ns/1ns
`include "cocs_regs.svh"

module cocs_edge_cmd
    import cocs_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_b,
    cocs_cmd_if.dec   cmd
);

    logic prev_go_reg;
    logic armed_reg;
    logic fire_reg;
    logic edge_ok;

    // Rising go bit, not disabled, decoder re-armed; codes 10 and 11 idle
    assign edge_ok = armed_reg && !prev_go_reg
                     && (cmd.code == `COCS_CODE_GO);      // [R07] [R04] [R12]

    //////////////////////////////////////////////////////////////////////////
    // Previous go bit between successive messages
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            prev_go_reg <= 1'b0;
        else if (cmd.strobe)
            prev_go_reg <= cmd.code[`COCS_CMD_BIT_GO];     // [R22]
    end

    //////////////////////////////////////////////////////////////////////////
    // A late message keeps the last code but disarms until 00 is seen
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            armed_reg <= 1'b1;
        else if (cmd.strobe && cmd.code == `COCS_CODE_IDLE)
            armed_reg <= 1'b1;                             // [R09]
        else if (cmd.hold && !cmd.strobe)
            armed_reg <= 1'b0;                             // [R08]
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            fire_reg <= 1'b0;
        else
            fire_reg <= cmd.strobe && edge_ok;
    end

    assign cmd.fire = fire_reg;

endmodule

// >>> cocs_handler.sv
// CAN object handler: position demand check, command bytes, status byte.
// Overview of operation
// R01 - Demand above 100 % code flags out-of-range and clamps to 100 %.
// R02 - Demand above maximum code raises demand fault, setpoint forced zero.
// R03 - Demand indication is unsigned 16 bit, valid only with CAN source.
// R04 - Clear active diagnostics on rising clear bit, only when not disabled.
// R05 - Clear logged diagnostics on rising third bit, fourth bit not set.
// R06 - Active clear matters only with latching; else faults drop themselves.
// R07 - Clear codes: 00 none, 01 clear, 10 and 11 no action.
// R08 - On message timeout hold last value; holding causes no clearing.
// R09 - After resume, a 00 must be seen before the next 01 acts.
// R10 - Clear-diagnostics command is byte three of receive PDO one.
// R11 - Run/stop command acts only when run permission source is CAN.
// R12 - Stop only on rising stop bit while stop-disable bit is zero.
// R13 - Run/stop codes: 00 run, 01 stop, 10 and 11 no action.
// R14 - Run/stop is byte four of receive PDO one; upper six bits spare.
// R15 - Status byte: 4-bit operating status, output bit, 3-bit demand state.
// R16 - Most severe present operating condition is reported.
// R17 - Operating codes 0 to 5 by severity, E error, F not available.
// R18 - Discrete output bit shows commanded output state, one is on.
// R19 - Demand state codes 0 to 4, 5 reserved, 6 error, 7 not available.
// R20 - Only extended 29-bit identifier frames are accepted.
// R21 - Position setpoint accepted only while a setpoint source is CAN.
// R22 - Previous command bits are kept to find rising edges.
// Assumes the CAN controller hands over decoded PDO bytes on ref_clk.
`timescale 1ns/1ns
`include "cocs_regs.svh"

module cocs_handler
    import cocs_pkg::*;
#(
    parameter int RX_W   = `COCS_RX_W,
    parameter int N_CHAN = 3
)
(
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    // Receive process data object
    input  wire logic              rx_valid,
    input  wire logic              rx_extended,
    input  wire logic [RX_W-1:0]   rx_data,
    input  wire logic              rx_timeout,
    // Configuration
    input  wire logic              dmd_src_can,
    input  wire logic              run_src_can,
    input  wire logic              fault_latch_en,
    // Conditions feeding the status byte
    input  wire logic              cond_alarm,
    input  wire logic              cond_alarm_hi,
    input  wire logic              cond_derate,
    input  wire logic              cond_ctrl_sd,
    input  wire logic              cond_limp_sd,
    input  wire logic              cond_error,
    input  wire logic              discrete_out_on,
    input  wire logic [2:0]        dmd_state_in,
    // Results
    output logic [15:0]            can_demand,
    output logic                   can_demand_valid,
    output logic [15:0]            setpoint,
    output logic                   dmd_oor_active,
    output logic                   dmd_fault_active,
    output logic                   clr_active_pulse,
    output logic                   clr_logged_pulse,
    output logic                   stop_active,
    output logic [7:0]             status_byte
);

    logic                 frame_ok;
    logic [15:0]          rx_pos;
    logic [7:0]           rx_diag;
    logic [7:0]           rx_cmd;
    logic                 pos_over_full;
    logic                 pos_over_max;
    logic [1:0]           chan_code [N_CHAN];
    logic [N_CHAN-1:0]    chan_strobe;
    logic [N_CHAN-1:0]    chan_fire;

    logic [15:0]          can_demand_reg;
    logic [15:0]          setpoint_reg;
    logic                 cause_oor_reg;
    logic                 cause_flt_reg;
    logic                 oor_latch_reg;
    logic                 flt_latch_reg;
    logic                 clr_act_reg;
    logic                 clr_log_reg;
    logic                 stop_reg;
    logic [7:0]           status_reg;
    cocs_op_status_t      op_next;
    cocs_dmd_state_t      dmd_next;

    //////////////////////////////////////////////////////////////////////////
    // Frame acceptance and byte extraction

    assign frame_ok = rx_valid && rx_extended;                     // [R20]
    assign rx_pos   = rx_data[`COCS_RX_POS_LSB +: 16];
    assign rx_diag  = rx_data[`COCS_RX_DIAG_LSB +: 8];             // [R10]
    // Upper six bits of the command byte are spare and ignored
    assign rx_cmd   = rx_data[`COCS_RX_CMD_LSB +: 8];              // [R14]

    assign pos_over_full = rx_pos > `COCS_POS_FULL;
    assign pos_over_max  = rx_pos > `COCS_POS_MAX;

    //////////////////////////////////////////////////////////////////////////
    // Position demand

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            can_demand_reg <= `COCS_POS_RST;
        else if (frame_ok && dmd_src_can)
            can_demand_reg <= rx_pos;                              // [R21]
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            setpoint_reg <= `COCS_POS_RST;
        else if (frame_ok && dmd_src_can)
        begin
            if (pos_over_max)
                setpoint_reg <= `COCS_POS_RST;                     // [R02]
            else if (pos_over_full)
                setpoint_reg <= `COCS_POS_FULL;                    // [R01]
            else
                setpoint_reg <= rx_pos;
        end
    end

    // Causes follow the last accepted demand; dropped if CAN is deselected
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            cause_oor_reg <= 1'b0;
            cause_flt_reg <= 1'b0;
        end
        else if (!dmd_src_can)
        begin
            cause_oor_reg <= 1'b0;
            cause_flt_reg <= 1'b0;
        end
        else if (frame_ok)
        begin
            cause_oor_reg <= pos_over_full && !pos_over_max;       // [R01]
            cause_flt_reg <= pos_over_max;                         // [R02]
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Active fault flags: latched only when latching is configured.
    // A cause present in the clearing cycle keeps the flag set.

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            oor_latch_reg <= 1'b0;
        else if (!fault_latch_en)
            oor_latch_reg <= cause_oor_reg;                        // [R06]
        else if (cause_oor_reg)
            oor_latch_reg <= 1'b1;
        else if (chan_fire[COCS_CH_CLR_ACT])
            oor_latch_reg <= 1'b0;                                 // [R06]
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            flt_latch_reg <= 1'b0;
        else if (!fault_latch_en)
            flt_latch_reg <= cause_flt_reg;                        // [R06]
        else if (cause_flt_reg)
            flt_latch_reg <= 1'b1;
        else if (chan_fire[COCS_CH_CLR_ACT])
            flt_latch_reg <= 1'b0;                                 // [R06]
    end

    //////////////////////////////////////////////////////////////////////////
    // Edge-triggered command channels

    assign chan_code[COCS_CH_CLR_ACT] =
        rx_diag[`COCS_DIAG_ACT_LSB +: 2];                          // [R04]
    assign chan_code[COCS_CH_CLR_LOG] =
        rx_diag[`COCS_DIAG_LOG_LSB +: 2];                          // [R05]
    assign chan_code[COCS_CH_STOP]    =
        rx_cmd[`COCS_RUN_LSB +: 2];                                // [R12]

    assign chan_strobe[COCS_CH_CLR_ACT] = frame_ok;
    assign chan_strobe[COCS_CH_CLR_LOG] = frame_ok;
    // Stop channel blind unless the run permission comes from CAN
    assign chan_strobe[COCS_CH_STOP]    = frame_ok && run_src_can; // [R11]

    generate
        for (genvar ch = 0; ch < N_CHAN; ch++)
        begin : g_chan
            cocs_cmd_if cmd_bus ();

            assign cmd_bus.strobe = chan_strobe[ch];
            assign cmd_bus.hold   = rx_timeout;                    // [R08]
            assign cmd_bus.code   = chan_code[ch];
            assign chan_fire[ch]  = cmd_bus.fire;

            cocs_edge_cmd u_edge
            (
                .ref_clk (ref_clk),
                .rst_b   (rst_b),
                .cmd     (cmd_bus.dec)
            );
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // Command results

    // Without latching an active clear has nothing to act on
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            clr_act_reg <= 1'b0;
        else
            clr_act_reg <= chan_fire[COCS_CH_CLR_ACT]
                           && fault_latch_en;                      // [R06]
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            clr_log_reg <= 1'b0;
        else
            clr_log_reg <= chan_fire[COCS_CH_CLR_LOG];             // [R05]
    end

    // Stop on a rising edge; a received 00 releases it as a level
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            stop_reg <= 1'b0;
        else if (!run_src_can)
            stop_reg <= 1'b0;                                      // [R11]
        else if (chan_fire[COCS_CH_STOP])
            stop_reg <= 1'b1;                                      // [R13]
        else if (chan_strobe[COCS_CH_STOP]
                 && chan_code[COCS_CH_STOP] == `COCS_CODE_IDLE)
            stop_reg <= 1'b0;                                      // [R13]
    end

    //////////////////////////////////////////////////////////////////////////
    // Status byte

    always_comb
    begin
        if (cond_error)
            op_next = COCS_OP_ERROR;                               // [R17]
        else if (cond_limp_sd)
            op_next = COCS_OP_LIMP_SD;                             // [R16]
        else if (cond_ctrl_sd)
            op_next = COCS_OP_CTRL_SD;
        else if (cond_derate)
            op_next = COCS_OP_DERATE;
        else if (cond_alarm_hi)
            op_next = COCS_OP_ALARM_HI;
        else if (cond_alarm)
            op_next = COCS_OP_ALARM;
        else
            op_next = COCS_OP_NORMAL;
    end

    // Reserved demand code is not passed on; shown as error instead
    always_comb
    begin
        if (dmd_state_in == COCS_DMD_RESERVED)
            dmd_next = COCS_DMD_ERROR;                             // [R19]
        else
            dmd_next = cocs_dmd_state_t'(dmd_state_in);            // [R19]
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            status_reg <= `COCS_ST_RST;
        else
        begin
            status_reg[`COCS_ST_OP_LSB +: 4]  <= op_next;          // [R15]
            status_reg[`COCS_ST_DO_BIT]       <= discrete_out_on;  // [R18]
            status_reg[`COCS_ST_DMD_LSB +: 3] <= dmd_next;         // [R15]
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs

    assign can_demand       = can_demand_reg;
    assign can_demand_valid = dmd_src_can;                         // [R03]
    assign setpoint         = setpoint_reg;
    assign dmd_oor_active   = oor_latch_reg;
    assign dmd_fault_active = flt_latch_reg;
    assign clr_active_pulse = clr_act_reg;
    assign clr_logged_pulse = clr_log_reg;
    assign stop_active      = stop_reg;
    assign status_byte      = status_reg;

endmodule

// >>> cocs_handler_props.sv
// Port assertions of the CAN object handler.
// Bound to cocs_handler below; one clock domain, synchronous reset.
`timescale 1ns/1ns

module cocs_handler_chk
#(
    parameter int RX_W = 32
)
(
    input wire logic            ref_clk,
    input wire logic            rst_b,
    input wire logic            rx_valid,
    input wire logic            rx_extended,
    input wire logic [RX_W-1:0] rx_data,
    input wire logic            dmd_src_can,
    input wire logic            run_src_can,
    input wire logic            cond_error,
    input wire logic            cond_limp_sd,
    input wire logic            discrete_out_on,
    input wire logic [2:0]      dmd_state_in,
    input wire logic            can_demand_valid,
    input wire logic [15:0]     setpoint,
    input wire logic            clr_active_pulse,
    input wire logic            clr_logged_pulse,
    input wire logic            stop_active,
    input wire logic [7:0]      status_byte
);
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    logic take;
    logic pos_ok;
    assign take = rx_valid && rx_extended && dmd_src_can;
    assign pos_ok = rx_data[15:0] <= 16'hfaff;

    ////////////////////////////////////////////////////////////////////////
    a_clamp_full: assert property (
        take && pos_ok && rx_data[15:0] > 16'h9c40 |=> setpoint == 16'h9c40)
        else $error("setpoint not clamped to full scale");
    a_fault_zero: assert property (
        take && !pos_ok |=> setpoint == 16'h0000)
        else $error("setpoint not forced to zero");
    a_pass_value: assert property (
        take && rx_data[15:0] <= 16'h9c40 |=> setpoint == $past(rx_data[15:0]))
        else $error("in-range demand not passed");
    a_valid_src: assert property (can_demand_valid == dmd_src_can)
        else $error("demand valid flag wrong");
    a_src_gate: assert property (
        rx_valid && !dmd_src_can |=> $stable(setpoint))
        else $error("setpoint moved without network source");
    a_ext_only: assert property (
        rx_valid && !rx_extended |=> $stable(setpoint))
        else $error("standard frame was taken");
    a_clr_cause: assert property (
        clr_active_pulse |->
        $past(rx_valid && rx_extended && rx_data[17:16] == 2'b01, 2))
        else $error("active clear without clear code");
    a_log_cause: assert property (
        clr_logged_pulse |->
        $past(rx_valid && rx_extended && rx_data[19:18] == 2'b01, 2))
        else $error("logged clear without clear code");
    a_stop_cause: assert property (
        $rose(stop_active) |-> $past(rx_valid && rx_extended
        && run_src_can && rx_data[25:24] == 2'b01, 2))
        else $error("stop without stop code");
    a_op_error: assert property (
        $past(rst_b) && $past(cond_error) |-> status_byte[3:0] == 4'he)
        else $error("error status not reported");
    a_op_limp: assert property (
        $past(rst_b && !cond_error && cond_limp_sd)
        |-> status_byte[3:0] == 4'h5)
        else $error("limp shutdown not most severe");
    a_out_bit: assert property (
        $past(rst_b) |-> status_byte[4] == $past(discrete_out_on))
        else $error("discrete output bit wrong");
    a_dmd_state: assert property (
        $past(rst_b) |-> status_byte[7:5] == (($past(dmd_state_in) == 3'h5)
        ? 3'h6 : $past(dmd_state_in)))
        else $error("demand state field wrong");

    c_clear: cover property (clr_active_pulse);
    c_stop: cover property ($rose(stop_active));
    c_zero: cover property (take && !pos_ok);
endmodule

bind cocs_handler cocs_handler_chk #(.RX_W(RX_W)) u_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .rx_valid(rx_valid),
    .rx_extended(rx_extended), .rx_data(rx_data), .dmd_src_can(dmd_src_can),
    .run_src_can(run_src_can), .cond_error(cond_error),
    .cond_limp_sd(cond_limp_sd), .discrete_out_on(discrete_out_on),
    .dmd_state_in(dmd_state_in), .can_demand_valid(can_demand_valid),
    .setpoint(setpoint), .clr_active_pulse(clr_active_pulse),
    .clr_logged_pulse(clr_logged_pulse), .stop_active(stop_active),
    .status_byte(status_byte));

// >>> cocs_net_master.sv
// Network master model: presents receive PDO1 frames to the handler.
// Frames start one small delay after a rising edge of ref_clk.
`timescale 1ns/1ns

module cocs_net_master
(
    input  wire logic   ref_clk,
    output logic        rx_valid,
    output logic        rx_extended,
    output logic [31:0] rx_data
);
    initial
    begin
        rx_valid = 1'b0;
        rx_extended = 1'b0;
        rx_data = 32'h0;
    end

    // Idle lines carry the inverse of the last frame, never a stale copy
    task automatic send(input logic ext, input logic [31:0] data);
        @(posedge ref_clk);
        #1;
        rx_valid = 1'b1;
        rx_extended = ext;
        rx_data = data;
        @(posedge ref_clk);
        #1;
        rx_valid = 1'b0;
        rx_extended = ~ext;
        rx_data = ~data;
    endtask
endmodule

// >>> tb_cocs_handler.sv
// Testbench of the CAN object handler: demand, commands, status byte.
// Frames come from the network master model; checker attached by bind.
`timescale 1ns/1ns

module tb_cocs_handler;
    logic        ref_clk, rst_b, rx_timeout, dmd_src_can, run_src_can;
    logic        fault_latch_en, discrete_out_on, rx_valid, rx_extended;
    logic        can_demand_valid, dmd_oor_active, dmd_fault_active;
    logic        clr_active_pulse, clr_logged_pulse, stop_active;
    logic [5:0]  cond;
    logic [2:0]  dmd_state_in;
    logic [31:0] rx_data;
    logic [15:0] can_demand, setpoint;
    logic [7:0]  status_byte;
    int          mismatches = 0, checks_done = 0, n_act = 0, n_log = 0;

    always #2 ref_clk = ~ref_clk;

    cocs_net_master net (.ref_clk(ref_clk), .rx_valid(rx_valid),
        .rx_extended(rx_extended), .rx_data(rx_data));

    cocs_handler dut (.ref_clk(ref_clk), .rst_b(rst_b), .rx_valid(rx_valid),
        .rx_extended(rx_extended), .rx_data(rx_data), .rx_timeout(rx_timeout),
        .dmd_src_can(dmd_src_can), .run_src_can(run_src_can),
        .fault_latch_en(fault_latch_en), .cond_alarm(cond[0]),
        .cond_alarm_hi(cond[1]), .cond_derate(cond[2]), .cond_ctrl_sd(cond[3]),
        .cond_limp_sd(cond[4]), .cond_error(cond[5]),
        .discrete_out_on(discrete_out_on), .dmd_state_in(dmd_state_in),
        .can_demand(can_demand), .can_demand_valid(can_demand_valid),
        .setpoint(setpoint), .dmd_oor_active(dmd_oor_active),
        .dmd_fault_active(dmd_fault_active),
        .clr_active_pulse(clr_active_pulse),
        .clr_logged_pulse(clr_logged_pulse), .stop_active(stop_active),
        .status_byte(status_byte));

    // Pulses counted mid-cycle, away from the edge that moves them
    always @(negedge ref_clk)
    begin
        n_act += int'(clr_active_pulse === 1'b1);
        n_log += int'(clr_logged_pulse === 1'b1);
    end

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic frame(input logic [15:0] pos, input logic [7:0] b3,
                         input logic [7:0] b4);
        net.send(1'b1, {b4, b3, pos});
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task automatic clr_try(input logic [7:0] b3, input int ea, input int el);
        int a0;
        int l0;
        a0 = n_act;
        l0 = n_log;
        frame(16'h0, b3, 8'h0);
        check("active clears", 16'(n_act - a0), 16'(ea));
        check("logged clears", 16'(n_log - l0), 16'(el));
    endtask

    task automatic stop_try(input logic [7:0] b4, input logic exp);
        frame(16'h0, 8'h0, b4);
        check("stop_active", stop_active, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_demand();
        logic [15:0] din [6] = '{16'h1234, 16'h9c40, 16'h9c41, 16'hfaff,
                                 16'hfb00, 16'hffff};
        logic [15:0] sp [6] = '{16'h1234, 16'h9c40, 16'h9c40, 16'h9c40,
                                16'h0000, 16'h0000};
        for (int i = 0; i < 6; i++)
        begin
            frame(din[i], 8'h0, 8'h0);
            check("setpoint", setpoint, sp[i]);
            check("can_demand", can_demand, din[i]);
            check("fault", dmd_fault_active, din[i] > 16'hfaff);
            if (din[i] <= 16'hfaff)
                check("oor", dmd_oor_active, din[i] > 16'h9c40);
        end
        net.send(1'b0, 32'h0000_0100);
        repeat (3) @(posedge ref_clk);
        #1;
        check("setpoint", setpoint, 16'h0000);
        frame(16'h0200, 8'h0, 8'h0);
        dmd_src_can = 1'b0;
        frame(16'h0300, 8'h0, 8'h0);
        check("setpoint", setpoint, 16'h0200);
        check("demand valid", can_demand_valid, 1'b0);
        dmd_src_can = 1'b1;
        $display("t_demand done");
    endtask

    task automatic t_clear();
        fault_latch_en = 1'b1;
        clr_try(8'h00, 0, 0);
        clr_try(8'h05, 1, 1);
        clr_try(8'h05, 0, 0);
        clr_try(8'h00, 0, 0);
        clr_try(8'h0f, 0, 0);
        clr_try(8'h00, 0, 0);
        clr_try(8'h0a, 0, 0);
        clr_try(8'h05, 1, 1);
        clr_try(8'h00, 0, 0);
        rx_timeout = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        rx_timeout = 1'b0;
        clr_try(8'h05, 0, 0);
        clr_try(8'h00, 0, 0);
        clr_try(8'h05, 1, 1);
        frame(16'h9c41, 8'h00, 8'h0);
        frame(16'h0000, 8'h00, 8'h0);
        check("held oor", dmd_oor_active, 1'b1);
        clr_try(8'h01, 1, 0);
        check("cleared oor", dmd_oor_active, 1'b0);
        clr_try(8'h00, 0, 0);
        fault_latch_en = 1'b0;
        clr_try(8'h05, 0, 1);
        $display("t_clear done");
    endtask

    task automatic t_stop();
        stop_try(8'h00, 1'b0);
        stop_try(8'h01, 1'b1);
        stop_try(8'h01, 1'b1);
        stop_try(8'hfc, 1'b0);
        stop_try(8'h03, 1'b0);
        stop_try(8'h00, 1'b0);
        stop_try(8'h01, 1'b1);
        stop_try(8'h02, 1'b1);
        rst_b = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        check("stop after reset", stop_active, 1'b0);
        run_src_can = 1'b0;
        stop_try(8'h01, 1'b0);
        run_src_can = 1'b1;
        $display("t_stop done");
    endtask

    task automatic t_status();
        logic [3:0] op;
        logic [2:0] ds;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge ref_clk);
            #1;
            cond = (i < 7) ? 6'h3f >> (6 - i) : 6'h20;
            discrete_out_on = i[0];
            dmd_state_in = i[2:0];
            op = (i < 6) ? i[3:0] : 4'he;
            ds = (i == 5) ? 3'h6 : i[2:0];
            repeat (2) @(posedge ref_clk);
            #1;
            check("op status", status_byte[3:0], op);
            check("out bit", status_byte[4], i[0]);
            check("dmd field", status_byte[7:5], ds);
        end
        $display("t_status done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        ref_clk = 1'b0;
        rst_b = 1'b0;
        {rx_timeout, fault_latch_en, discrete_out_on} = 3'h0;
        {dmd_src_can, run_src_can} = 2'h3;
        cond = 6'h00;
        dmd_state_in = 3'h0;
        repeat (6) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        t_demand();
        t_clear();
        t_stop();
        t_status();
        report_and_stop();
    end

    // Whole run is a few hundred cycles
    initial
    begin
        #20000;
        mismatches++;
        report_and_stop();
    end
endmodule
